//--- core/otc_pkg.sv
package otc_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OFS0 = 4'h4;
    localparam logic [3:0] ADDR_OFS1 = 4'h8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OFS_RESET = 8'h20;
    localparam logic [7:0] CTRL_WMASK = 8'h33;
    localparam int BIT_AMP1_OUT = 7;
    localparam int BIT_AMP0_OUT = 3;
    localparam int BIT_CAL_MODE = 7;
    localparam int BIT_CAL_REF = 6;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- core/otc_amp_out.sv
`timescale 1ns/1ns
// digital output of one amplifier, sampled on core_clk
module otc_amp_out (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic amp_enable,
    input wire logic cal_mode,
    input wire logic amp_out,
    input wire logic comp_out,
    output logic digital_out
);
    typedef struct packed {
        logic q;
    } otc_out_st_t;
    otc_out_st_t st;
    otc_out_st_t next_st;

    always_comb
    begin
        next_st = st;
        // disabled reads zero
        if (!amp_enable)
            next_st.q = 1'b0;
        // calibration picks comparator
        else if (cal_mode)
            next_st.q = comp_out;
        else
            next_st.q = amp_out;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign digital_out = st.q;

    chk_off_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
        !amp_enable |=> !digital_out) else $error("output not zero when disabled");
    chk_cal_follows_comp: assert property (@(posedge core_clk) disable iff (rst)
        amp_enable && cal_mode |=> digital_out == $past(comp_out)) else $error("comparator not shown");
    chk_normal_follows_out: assert property (@(posedge core_clk) disable iff (rst)
        amp_enable && !cal_mode |=> digital_out == $past(amp_out)) else $error("output not followed");
endmodule

//--- core/otc_regs.sv
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
// amplifier bandwidth, output and offset trim registers on axi4-lite
module otc_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic amp0_enable,
    input wire logic amp1_enable,
    input wire logic amp0_out,
    input wire logic amp1_out,
    input wire logic amp0_comp,
    input wire logic amp1_comp,
    output logic [1:0] amp0_bandwidth_sel,
    output logic [1:0] amp1_bandwidth_sel,
    output logic amp0_cal_mode,
    output logic amp1_cal_mode,
    output logic amp0_cal_ref_sel,
    output logic amp1_cal_ref_sel,
    output logic [5:0] amp0_trim_code,
    output logic [5:0] amp1_trim_code
);
    typedef struct packed {
        logic aw_held;
        logic [3:0] aw_addr;
        logic aw_ok;
        logic w_held;
        logic [7:0] w_data;
        logic w_strb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
        logic [7:0] ofs0;
        logic [7:0] ofs1;
    } otc_st_t;
    otc_st_t st;
    otc_st_t next_st;
    logic amp0_digital_out;
    logic amp1_digital_out;

    // true for the three mapped word addresses
    function automatic logic otc_mapped(input logic [31:0] a);
        return a[31:4] == 28'h0000000 && a[1:0] == 2'b00 && a[3:0] != 4'hc;
    endfunction

    always_comb
    begin
        next_st = st;
        if (s_axi_awvalid && !st.aw_held)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr[3:0];
            // decided on the full address so that high aliases of a register are refused
            next_st.aw_ok = otc_mapped(s_axi_awaddr);
        end
        if (s_axi_wvalid && !st.w_held)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_strb0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        // commit once both halves are held and no response is pending
        if (st.aw_held && st.w_held && !st.bvalid)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = st.aw_ok ? otc_pkg::RESP_OKAY : otc_pkg::RESP_SLVERR;
            if (st.w_strb0 && st.aw_ok)
            begin
                case (st.aw_addr)
                    otc_pkg::ADDR_CTRL: next_st.ctrl = st.w_data & otc_pkg::CTRL_WMASK;
                    otc_pkg::ADDR_OFS0: next_st.ofs0 = st.w_data;
                    otc_pkg::ADDR_OFS1: next_st.ofs1 = st.w_data;
                    default: next_st.ctrl = st.ctrl;
                endcase
            end
        end
        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (s_axi_arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = otc_mapped(s_axi_araddr) ? otc_pkg::RESP_OKAY : otc_pkg::RESP_SLVERR;
            case (s_axi_araddr[3:0])
                // live outputs merged in, bits 6 and 2 stay zero
                otc_pkg::ADDR_CTRL: next_st.rdata = {amp1_digital_out, st.ctrl[6:4], amp0_digital_out, st.ctrl[2:0]};
                otc_pkg::ADDR_OFS0: next_st.rdata = st.ofs0;
                otc_pkg::ADDR_OFS1: next_st.rdata = st.ofs1;
                default: next_st.rdata = 8'h00;
            endcase
            if (!otc_mapped(s_axi_araddr))
                next_st.rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.ctrl <= otc_pkg::CTRL_RESET;
            st.ofs0 <= otc_pkg::OFS_RESET;
            st.ofs1 <= otc_pkg::OFS_RESET;
        end
        else
            st <= next_st;
    end

    otc_amp_out u_out0 (
        .core_clk(core_clk),
        .rst(rst),
        .amp_enable(amp0_enable),
        .cal_mode(st.ofs0[otc_pkg::BIT_CAL_MODE]),
        .amp_out(amp0_out),
        .comp_out(amp0_comp),
        .digital_out(amp0_digital_out)
    );
    otc_amp_out u_out1 (
        .core_clk(core_clk),
        .rst(rst),
        .amp_enable(amp1_enable),
        .cal_mode(st.ofs1[otc_pkg::BIT_CAL_MODE]),
        .amp_out(amp1_out),
        .comp_out(amp1_comp),
        .digital_out(amp1_digital_out)
    );

    // ready is a register image so a held request is never taken twice
    assign s_axi_awready = !st.aw_held;
    assign s_axi_wready = !st.w_held;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = {24'h000000, st.rdata};
    assign amp1_bandwidth_sel = st.ctrl[5:4];
    assign amp0_bandwidth_sel = st.ctrl[1:0];
    assign amp0_cal_mode = st.ofs0[otc_pkg::BIT_CAL_MODE];
    assign amp0_cal_ref_sel = st.ofs0[otc_pkg::BIT_CAL_REF];
    assign amp0_trim_code = st.ofs0[5:0];
    assign amp1_cal_mode = st.ofs1[otc_pkg::BIT_CAL_MODE];
    assign amp1_cal_ref_sel = st.ofs1[otc_pkg::BIT_CAL_REF];
    assign amp1_trim_code = st.ofs1[5:0];

    chk_unimpl_bits_zero: assert property (@(posedge core_clk) disable iff (rst)
        st.ctrl[7:6] == 2'b00 && st.ctrl[3:2] == 2'b00) else $error("unimplemented control bits set");
    chk_ofs0_write_lands: assert property (@(posedge core_clk) disable iff (rst)
        st.aw_held && st.w_held && !st.bvalid && st.w_strb0 && st.aw_addr == otc_pkg::ADDR_OFS0
        |=> amp0_trim_code == $past(st.w_data[5:0])) else $error("trim 0 write lost");
    chk_ofs1_write_lands: assert property (@(posedge core_clk) disable iff (rst)
        st.aw_held && st.w_held && !st.bvalid && st.w_strb0 && st.aw_addr == otc_pkg::ADDR_OFS1
        |=> {amp1_cal_mode, amp1_cal_ref_sel, amp1_trim_code} == $past(st.w_data)) else $error("trim 1 write lost");
    chk_bw_write_lands: assert property (@(posedge core_clk) disable iff (rst)
        st.aw_held && st.w_held && !st.bvalid && st.w_strb0 && st.aw_addr == otc_pkg::ADDR_CTRL
        |=> amp1_bandwidth_sel == $past(st.w_data[5:4]) && amp0_bandwidth_sel == $past(st.w_data[1:0]))
        else $error("bandwidth write lost");
    chk_read_ctrl_outs: assert property (@(posedge core_clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h00000000
        |=> s_axi_rdata[7] == $past(amp1_digital_out) && s_axi_rdata[3] == $past(amp0_digital_out))
        else $error("read lost output bits");

    // a write whose both halves are held and whose response slot is free
    sequence otc_wr_commit;
        st.aw_held && st.w_held && !st.bvalid;
    endsequence
    // a read address taken on this edge
    sequence otc_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_bvalid_holds: assert property (@(posedge core_clk) disable iff (rst)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rvalid_holds: assert property (@(posedge core_clk) disable iff (rst)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_commit_answers: assert property (@(posedge core_clk) disable iff (rst)
        otc_wr_commit |=> s_axi_bvalid)
        else $error("write not answered");
    chk_bad_write_err: assert property (@(posedge core_clk) disable iff (rst)
        otc_wr_commit ##0 !st.aw_ok |=> s_axi_bresp == otc_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    chk_bad_write_keeps: assert property (@(posedge core_clk) disable iff (rst)
        otc_wr_commit ##0 !st.aw_ok |=> $stable(st.ctrl) && $stable(st.ofs0) && $stable(st.ofs1))
        else $error("unmapped write changed a register");
    chk_strb_off_keeps: assert property (@(posedge core_clk) disable iff (rst)
        otc_wr_commit ##0 !st.w_strb0 |=> $stable(st.ctrl) && $stable(st.ofs0) && $stable(st.ofs1))
        else $error("disabled lane changed a register");
    chk_read_answers: assert property (@(posedge core_clk) disable iff (rst)
        otc_rd_take |=> s_axi_rvalid)
        else $error("read not answered");
    chk_read_unmapped: assert property (@(posedge core_clk) disable iff (rst)
        otc_rd_take ##0 !otc_mapped(s_axi_araddr)
        |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == otc_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    chk_read_ofs0: assert property (@(posedge core_clk) disable iff (rst)
        otc_rd_take ##0 s_axi_araddr == 32'h00000004 |=> s_axi_rdata[7:0] == $past(st.ofs0))
        else $error("trim 0 read wrong");
    chk_read_ofs1: assert property (@(posedge core_clk) disable iff (rst)
        otc_rd_take ##0 s_axi_araddr == 32'h00000008 |=> s_axi_rdata[7:0] == $past(st.ofs1))
        else $error("trim 1 read wrong");
endmodule

//--- dv/otc_regs_tb.sv
`timescale 1ns/1ns
module otc_regs_tb;
    localparam logic [5:0] THR = 6'h17;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd_val;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, amp0_bandwidth_sel, amp1_bandwidth_sel, rd_rsp;
    logic amp0_enable = 1'b0, amp1_enable = 1'b0, amp0_out = 1'b0, amp1_out = 1'b0;
    logic comp0 = 1'b0, amp1_comp = 1'b0, cal_on = 1'b0;
    logic amp0_comp, amp0_cal_mode, amp1_cal_mode, amp0_cal_ref_sel, amp1_cal_ref_sel;
    logic [5:0] amp0_trim_code, amp1_trim_code;
    logic [7:0] pats [4] = '{8'h00, 8'h3f, 8'h40, 8'h95};
    int err_total = 0, n_tests = 0, cyc = 0;
    // comparator stand-in: flips once the trim code reaches a fixed point
    assign amp0_comp = cal_on ? (amp0_trim_code >= THR) : comp0;
    otc_regs u_otc_regs (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .amp0_enable,
        .amp1_enable, .amp0_out, .amp1_out, .amp0_comp, .amp1_comp, .amp0_bandwidth_sel, .amp1_bandwidth_sel,
        .amp0_cal_mode, .amp1_cal_mode, .amp0_cal_ref_sel, .amp1_cal_ref_sel, .amp0_trim_code, .amp1_trim_code);
    always #10 core_clk = ~core_clk;
    task automatic complete_run();
        $display("errors %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h0, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd_val = s_axi_rdata;
        rd_rsp = s_axi_rresp;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a);
        chk(rd_val, e);
        chk({30'h0, rd_rsp}, {30'h0, er});
    endtask
    // software trim search; stops at the first toggle or at the end of the range
    task automatic search(input logic [5:0] start, input logic up, output logic [5:0] hit);
        logic prev;
        hit = start;
        wr(32'h4, {2'b11, hit}, 4'h1, 2'b00);
        rd(32'h0);
        prev = rd_val[3];
        do
        begin
            hit = up ? hit + 6'h1 : hit - 6'h1;
            wr(32'h4, {2'b11, hit}, 4'h1, 2'b00);
            rd(32'h0);
        end while (rd_val[3] === prev && hit != (up ? 6'h3f : 6'h00));
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            err_total++;
            complete_run();
        end
    end
    initial
    begin
        logic [5:0] v1, v2;
        logic [6:0] sum;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(32'h0, 32'h0, 2'b00);
        rd_chk(32'h4, 32'h20, 2'b00);
        rd_chk(32'h8, 32'h20, 2'b00);
        for (int c = 0; c < 4; c++)
        begin
            wr(32'h0, {2'b11, c[1:0], 2'b11, c[1:0]}, 4'h1, 2'b00);
            rd_chk(32'h0, {26'h0, c[1:0], 2'b00, c[1:0]}, 2'b00);
            chk({28'h0, amp1_bandwidth_sel, amp0_bandwidth_sel}, {28'h0, c[1:0], c[1:0]});
        end
        for (int m = 0; m < 2; m++)
        begin
            wr(32'h4, {m[0], 7'h20}, 4'h1, 2'b00);
            wr(32'h8, {m[0], 7'h20}, 4'h1, 2'b00);
            for (int i = 0; i < 8; i++)
            begin
                @(posedge core_clk);
                {amp0_enable, amp0_out, comp0} <= i[2:0];
                {amp1_enable, amp1_out, amp1_comp} <= {i[2], ~i[1:0]};
                rd(32'h0);
                chk({30'h0, rd_val[7], rd_val[3]}, {30'h0, i[2] & ~(m[0] ? i[0] : i[1]),
                    i[2] & (m[0] ? i[0] : i[1])});
            end
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(32'h4, pats[k], 4'h1, 2'b00);
            wr(32'h8, ~pats[k], 4'h1, 2'b00);
            rd_chk(32'h4, {24'h0, pats[k]}, 2'b00);
            rd_chk(32'h8, {24'h0, ~pats[k]}, 2'b00);
            chk({16'h0, amp0_cal_mode, amp0_cal_ref_sel, amp0_trim_code, amp1_cal_mode, amp1_cal_ref_sel,
                amp1_trim_code}, {16'h0, pats[k], ~pats[k]});
        end
        wr(32'h4, 8'h15, 4'h0, 2'b00);
        rd_chk(32'h4, {24'h0, pats[3]}, 2'b00);
        wr(32'hc, 8'h15, 4'h1, 2'b10);
        rd_chk(32'hc, 32'h0, 2'b10);
        wr(32'h14, 8'h15, 4'h1, 2'b10);
        rd_chk(32'h4, {24'h0, pats[3]}, 2'b00);
        rd_chk(32'h14, 32'h0, 2'b10);
        @(posedge core_clk);
        {amp0_enable, cal_on} <= 2'b11;
        wr(32'h4, 8'hc0, 4'h1, 2'b00);
        search(6'h00, 1'b1, v1);
        search(6'h3f, 1'b0, v2);
        chk({26'h0, v1}, {26'h0, THR});
        chk({26'h0, v2}, {26'h0, THR - 6'h1});
        sum = {1'b0, v1} + {1'b0, v2};
        wr(32'h4, {2'b11, sum[6:1]}, 4'h1, 2'b00);
        chk({26'h0, amp0_trim_code}, {26'h0, 6'h16});
        complete_run();
    end
endmodule
